// ===== lpsd_regs.svh
// Timing counts, mode register addresses, field positions and reset values of the SDRAM link
`ifndef LPSD_REGS_SVH
`define LPSD_REGS_SVH
`define LPSD_CLK_PERIOD_PS 10000
`define LPSD_CKE_LOW_HOLD_NS 100
`define LPSD_CLOCK_SETTLE_TCK 5
`define LPSD_POWER_UP_IDLE_US 200
`define LPSD_POST_RESET_IDLE_US 1
`define LPSD_AUTO_INIT_MAX_US 10
`define LPSD_INITIAL_CAL_US 1
`define LPSD_BOOT_CLK_MIN_NS 18
`define LPSD_BOOT_CLK_MAX_NS 100
// Least times round up, longest times round down, none below one cycle
`define LPSD_CYC_UP(ps) (((ps) + `LPSD_CLK_PERIOD_PS - 1) / `LPSD_CLK_PERIOD_PS)
`define LPSD_CYC_DN(ps) ((((ps) / `LPSD_CLK_PERIOD_PS) > 0) ? ((ps) / `LPSD_CLK_PERIOD_PS) : 1)
`define LPSD_CKE_LOW_CYC `LPSD_CYC_UP(`LPSD_CKE_LOW_HOLD_NS * 1000)
`define LPSD_POWER_UP_IDLE_CYC `LPSD_CYC_UP(`LPSD_POWER_UP_IDLE_US * 1000000)
`define LPSD_POST_RESET_CYC `LPSD_CYC_UP(`LPSD_POST_RESET_IDLE_US * 1000000)
`define LPSD_AUTO_INIT_MAX_CYC `LPSD_CYC_DN(`LPSD_AUTO_INIT_MAX_US * 1000000)
`define LPSD_INITIAL_CAL_CYC `LPSD_CYC_UP(`LPSD_INITIAL_CAL_US * 1000000)
// Mode register addresses
`define LPSD_MA_DEVICE_INFO 6'h00
`define LPSD_MA_FEATURE1 6'h01
`define LPSD_MA_FEATURE2 6'h02
`define LPSD_MA_FEATURE3 6'h03
`define LPSD_MA_IMPEDANCE_CAL 6'h0A
`define LPSD_MA_RESET 6'h3F
// Field positions and reset values
`define LPSD_AUTO_INIT_BIT 0
`define LPSD_FEATURE1_RST 8'h02
`define LPSD_FEATURE2_RST 8'h01
`define LPSD_FEATURE3_RST 8'h02
`define LPSD_CAL_CODE_RST 8'hFF
`define LPSD_CAL_INIT_CODE 8'hFF
`endif

// ===== lpsd_pkg.sv
// Command type shared by both ends of the SDRAM command link, plus the state type of each end
package lpsd_pkg;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_RD = 4'h2, CMD_WR = 4'h3,
    CMD_PRE = 4'h4, CMD_PREA = 4'h5, CMD_MRW = 4'h6, CMD_MRR = 4'h7
  } lpsd_cmd_e;
  typedef enum logic [2:0] {
    DEV_PWRUP = 3'b001, DEV_AUTOINIT = 3'b010, DEV_IDLE = 3'b100
  } lpsd_dev_e;
  typedef enum logic [12:0] {
    C_CKE_LOW = 13'h0001, C_PWR_IDLE = 13'h0002, C_PREA = 13'h0004,
    C_RESET = 13'h0008, C_POST_RST = 13'h0010, C_AI_WAIT = 13'h0020,
    C_AI_POLL = 13'h0040, C_AI_RESP = 13'h0080, C_CAL_REQ = 13'h0100,
    C_CAL_WAIT = 13'h0200, C_FEAT = 13'h0400, C_READY = 13'h0800,
    C_WDATA = 13'h1000
  } lpsd_ctl_e;
endpackage

// ===== lpsd_link_if.sv
// Command/address and data link between the controller end and the memory end
`timescale 1ns/1ps
interface lpsd_link_if #(parameter int DQ_W = 8) (input wire logic ref_clk);
  logic cke;
  logic csB;
  logic [9:0] caRise;
  logic [9:0] caFall;
  logic [2*DQ_W-1:0] devDq;
  logic devDqOeB;
  logic devStrobe;
  logic [2*DQ_W-1:0] ctlDq;
  logic ctlDqOeB;
  logic [2*DQ_W-1:0] dq;
  // Shared data wire: the end whose enable is low drives it
  assign dq = !devDqOeB ? devDq : (!ctlDqOeB ? ctlDq : '0);
  modport mem (input cke, csB, caRise, caFall, dq, output devDq, devDqOeB, devStrobe);
  modport ctl (output cke, csB, caRise, caFall, ctlDq, ctlDqOeB, input dq, devStrobe);
endinterface

// ===== lpsd_mem_end.sv
// Memory end: command decode, init state, banks, burst engine and storage array
`timescale 1ns/1ps
`include "lpsd_regs.svh"
module lpsd_mem_end import lpsd_pkg::*; #(
  parameter int DQ_W = 8,
  parameter int ROW_W = 2,
  parameter int COL_W = 3,
  parameter int AUTO_INIT_CYC = 500
) (
  input wire logic ref_clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  lpsd_link_if.mem link, // Link from the controller
  output logic idleState, // Init done and all banks precharged
  output logic autoInitBusy, // Auto-init flag
  output logic calBusy, // Initial calibration running
  output logic cmdErr // Pulse: last command refused
);
  localparam int WORD_W = 4 * DQ_W;
  localparam int ADDR_W = 3 + ROW_W + COL_W;
  localparam int AI_MAX = `LPSD_AUTO_INIT_MAX_CYC;
  localparam int AI_CYC = (AUTO_INIT_CYC < AI_MAX) ? AUTO_INIT_CYC : AI_MAX;
  localparam int CAL_CYC = `LPSD_INITIAL_CAL_CYC;
  localparam int AI_W = $clog2(AI_MAX + 1);
  localparam int CAL_W = $clog2(CAL_CYC + 1);

  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  lpsd_dev_e state_ff, nxt_state;
  logic [AI_W-1:0] aiCnt_ff;
  logic [CAL_W-1:0] calCnt_ff;
  logic [7:0] feat1_ff, feat2_ff, feat3_ff, calCode_ff;
  logic [7:0] openMask;
  logic [ROW_W-1:0] openRow [0:7];
  logic [3:0] rdCyc_ff, wrCyc_ff;
  logic [ADDR_W-1:0] rdAddr_ff, wrAddr_ff;
  logic [2*DQ_W-1:0] wrLow_ff, dqOut_ff;
  logic drive_ff, cmdErr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode; both halves of the cycle carry command fields
  wire logic cmdOn = link.cke && !link.csB;
  wire lpsd_cmd_e op = lpsd_cmd_e'(link.caRise[3:0]);
  wire logic [2:0] bank = link.caRise[6:4];
  wire logic [5:0] ma = link.caRise[9:4];
  wire logic [7:0] opd = link.caFall[7:0];
  wire logic [ROW_W-1:0] row = link.caFall[ROW_W-1:0];
  wire logic [COL_W-1:0] col = link.caFall[COL_W-1:0];
  wire logic ready = (state_ff == DEV_IDLE);
  wire logic busBusy = (rdCyc_ff != 4'h0) || (wrCyc_ff != 4'h0);
  wire logic isReset = cmdOn && op == CMD_MRW && ma == `LPSD_MA_RESET;
  wire logic doAct = cmdOn && ready && op == CMD_ACT && !openMask[bank];
  wire logic doRd = cmdOn && ready && op == CMD_RD && openMask[bank] && !busBusy;
  wire logic doWr = cmdOn && ready && op == CMD_WR && openMask[bank] && !busBusy;
  wire logic doPre = cmdOn && ready && op == CMD_PRE;
  wire logic doPrea = cmdOn && (ready || state_ff == DEV_PWRUP) && op == CMD_PREA;
  wire logic doMrw = cmdOn && ready && op == CMD_MRW && !isReset;
  // After reset only mode-register reads and a repeated reset are served until auto-init ends
  wire logic doMrr = cmdOn && (ready || state_ff == DEV_AUTOINIT) && op == CMD_MRR
    && !busBusy;
  wire logic accepted = isReset || doAct || doRd || doWr || doPre || doPrea || doMrw || doMrr;
  // Read/write address is bank, open row of that bank and start column
  wire logic [ADDR_W-1:0] caAddr = {bank, openRow[bank], col};
  // Burst length from feature register 1: 4, 8 or 16 beats, two beats a cycle
  wire logic [3:0] burstCyc = (feat1_ff[2:0] == 3'h4) ? 4'h8 :
    ((feat1_ff[2:0] == 3'h3) ? 4'h4 : 4'h2);
  wire logic [COL_W-1:0] colMask = COL_W'(burstCyc[3:1] - 3'h1);
  wire logic [7:0] mrValue = (ma == `LPSD_MA_DEVICE_INFO) ?
    8'(autoInitBusy) << `LPSD_AUTO_INIT_BIT : 8'h00;
  wire logic [WORD_W-1:0] rdWord = mem[rdAddr_ff];
  // Odd count is the second half of a word: low half already held
  wire logic memWe = (wrCyc_ff != 4'h0) && wrCyc_ff[0];

  // Sequential order, wrapping inside the burst-aligned column block
  function automatic logic [ADDR_W-1:0] stepAddr(input logic [ADDR_W-1:0] a,
                                                 input logic [COL_W-1:0] m);
    logic [COL_W-1:0] c;
    c = a[COL_W-1:0];
    c = (c & ~m) | ((c + COL_W'(1)) & m);
    return {a[ADDR_W-1:COL_W], c};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Init state machine: power-up, auto-init, idle
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      DEV_PWRUP: if (isReset) nxt_state = DEV_AUTOINIT;
      DEV_AUTOINIT: if (!isReset && aiCnt_ff == '0) nxt_state = DEV_IDLE;
      DEV_IDLE: if (isReset) nxt_state = DEV_AUTOINIT;
    endcase
  end

  // State, auto-init timer and calibration timer
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_ff <= DEV_PWRUP;
      aiCnt_ff <= '0;
      calCnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (isReset) aiCnt_ff <= AI_W'(AI_CYC);
      else if (aiCnt_ff != '0) aiCnt_ff <= aiCnt_ff - AI_W'(1);
      if (isReset) calCnt_ff <= '0;
      else if (doMrw && ma == `LPSD_MA_IMPEDANCE_CAL) calCnt_ff <= CAL_W'(CAL_CYC);
      else if (calCnt_ff != '0) calCnt_ff <= calCnt_ff - CAL_W'(1);
    end
  end

  // Mode registers written by the controller
  always_ff @(posedge ref_clk) begin
    if (!rst_b || isReset) begin
      feat1_ff <= `LPSD_FEATURE1_RST;
      feat2_ff <= `LPSD_FEATURE2_RST;
      feat3_ff <= `LPSD_FEATURE3_RST;
      calCode_ff <= `LPSD_CAL_CODE_RST;
    end else if (doMrw) begin
      if (ma == `LPSD_MA_FEATURE1) feat1_ff <= opd;
      if (ma == `LPSD_MA_FEATURE2) feat2_ff <= opd;
      if (ma == `LPSD_MA_FEATURE3) feat3_ff <= opd;
      if (ma == `LPSD_MA_IMPEDANCE_CAL) calCode_ff <= opd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Eight independent banks, each with its open row
  for (genvar b = 0; b < 8; b++) begin : g_bank
    logic open_ff;
    logic [ROW_W-1:0] row_ff;
    always_ff @(posedge ref_clk) begin
      if (!rst_b || isReset) begin
        open_ff <= 1'b0;
        row_ff <= '0;
      end else if (doAct && bank == 3'(b)) begin
        open_ff <= 1'b1;
        row_ff <= row;
      end else if ((doPre && bank == 3'(b)) || doPrea) begin
        open_ff <= 1'b0;
      end
    end
    assign openMask[b] = open_ff;
    assign openRow[b] = row_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst engine: one 4n word per core access, two n-pairs on the pins
  always_ff @(posedge ref_clk) begin
    if (!rst_b || isReset) begin
      rdCyc_ff <= 4'h0;
      wrCyc_ff <= 4'h0;
      rdAddr_ff <= '0;
      wrAddr_ff <= '0;
      wrLow_ff <= '0;
      dqOut_ff <= '0;
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= 1'b0;
      if (doMrr) begin
        dqOut_ff <= (2*DQ_W)'(mrValue);
        drive_ff <= 1'b1;
      end else if (doRd) begin
        rdCyc_ff <= burstCyc;
        rdAddr_ff <= caAddr;
      end else if (rdCyc_ff != 4'h0) begin
        dqOut_ff <= rdCyc_ff[0] ? rdWord[WORD_W-1:2*DQ_W] : rdWord[2*DQ_W-1:0];
        drive_ff <= 1'b1;
        rdCyc_ff <= rdCyc_ff - 4'h1;
        if (rdCyc_ff[0]) rdAddr_ff <= stepAddr(rdAddr_ff, colMask);
      end
      if (doWr) begin
        wrCyc_ff <= burstCyc;
        wrAddr_ff <= caAddr;
      end else if (wrCyc_ff != 4'h0) begin
        wrCyc_ff <= wrCyc_ff - 4'h1;
        if (!memWe) wrLow_ff <= link.dq;
        else wrAddr_ff <= stepAddr(wrAddr_ff, colMask);
      end
    end
  end

  // Core write: whole 4n word once its second half arrives
  always_ff @(posedge ref_clk) begin
    if (memWe) mem[wrAddr_ff] <= {link.dq, wrLow_ff};
  end

  // Refused command flag
  always_ff @(posedge ref_clk) begin
    if (!rst_b) cmdErr_ff <= 1'b0;
    else cmdErr_ff <= cmdOn && op != CMD_NOP && !accepted;
  end

  // Pins stay released while the clock-enable gate is low
  assign link.devDq = dqOut_ff;
  assign link.devStrobe = drive_ff && link.cke;
  assign link.devDqOeB = !(drive_ff && link.cke);
  assign idleState = ready && (openMask == 8'h00);
  assign autoInitBusy = (state_ff != DEV_IDLE);
  assign calBusy = (calCnt_ff != '0);
  assign cmdErr = cmdErr_ff;
endmodule

// ===== lpsd_ctl_end.sv
// Controller end: power-up sequencer, command issue, write data and read FIFO
// Functional notes
// - Ten-bit command/address bus carries every command
// - One cycle per command, both halves used
// - Access is one 4n word, four n-beats
// - Bursts run programmed length in sequential order
// - Activate a row before read or write
// - Read/write address gives bank and column
// - Eight banks; idle means all precharged
// - Gate low at power; device pins released
// - Gate low at least 100 ns
// - Five stable clocks before gate rises
// - Mode reads only at 18-100 ns period
// - Mode writes allowed at normal clock rate
// - Gate high, only no-ops for 200 us
// - Reset write after idle, optional precharge-all
// - Only no-ops during post-reset idle time
// - After that: mode reads and power-down only
// - Device clears auto-init flag, enters idle
// - Poll the flag or wait maximum time
// - Issue initial calibration, wait its time
// - Shared bus: calibrations never overlap
// - Post-reset idle at least 1 us
// - Auto-init done within 10 us
// - Then write feature registers one to three
`timescale 1ns/1ps
`include "lpsd_regs.svh"

// Read data buffer with valid/ready on both sides
module lpsd_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic inValid, // Write side valid
  output logic inReady, // Write side ready (not full)
  input wire logic [W-1:0] inData, // Write data
  output logic outValid, // Read side valid (not empty)
  input wire logic outReady, // Read side ready
  output logic [W-1:0] outData, // Head word
  output logic [$clog2(DEPTH+1)-1:0] level // Words held
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] buf_ff [0:DEPTH-1];
  logic [PW-1:0] wrPtr_ff, rdPtr_ff;
  logic [CW-1:0] cnt_ff;
  wire logic push = inValid && inReady;
  wire logic pop = outValid && outReady;

  // Pointers and fill count
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wrPtr_ff <= (wrPtr_ff == PW'(DEPTH - 1)) ? '0 : wrPtr_ff + PW'(1);
      if (pop) rdPtr_ff <= (rdPtr_ff == PW'(DEPTH - 1)) ? '0 : rdPtr_ff + PW'(1);
      cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
    end
  end

  // Storage
  always_ff @(posedge ref_clk) begin
    if (push) buf_ff[wrPtr_ff] <= inData;
  end

  assign inReady = (cnt_ff != CW'(DEPTH));
  assign outValid = (cnt_ff != '0);
  assign outData = buf_ff[rdPtr_ff];
  assign level = cnt_ff;
endmodule

////////////////////////////////////////////////////////////////////////////////
module lpsd_ctl_end import lpsd_pkg::*; #(
  parameter int DQ_W = 8,
  parameter int ROW_W = 2,
  parameter int COL_W = 3,
  parameter int FIFO_DEPTH = 8,
  parameter int POWER_UP_IDLE_CYC = `LPSD_POWER_UP_IDLE_CYC,
  parameter bit POLL_AUTO_INIT = 1'b0,
  parameter bit PRECHARGE_FIRST = 1'b1,
  parameter logic [7:0] FEATURE1_VAL = `LPSD_FEATURE1_RST,
  parameter logic [7:0] FEATURE2_VAL = `LPSD_FEATURE2_RST,
  parameter logic [7:0] FEATURE3_VAL = `LPSD_FEATURE3_RST
) (
  input wire logic ref_clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  lpsd_link_if.ctl link, // Link to the memory
  output logic initDone, // Init sequence finished
  output logic calReq, // Wants the shared calibration slot
  input wire logic calGrant, // Calibration slot granted
  input wire logic cmdValid, // User command valid
  output logic cmdReady, // User command taken
  input wire lpsd_cmd_e cmdOp, // ACT, RD, WR or PRE
  input wire logic [2:0] cmdBank, // Bank
  input wire logic [ROW_W-1:0] cmdRow, // Row for ACT
  input wire logic [COL_W-1:0] cmdCol, // Column for RD/WR
  input wire logic [4*DQ_W-1:0] cmdWrData, // Write word for WR
  output logic rdValid, // Read data valid
  input wire logic rdReady, // Read data taken
  output logic [2*DQ_W-1:0] rdData // Read data, one beat pair
);
  localparam int CKE_LOW = (`LPSD_CKE_LOW_CYC > `LPSD_CLOCK_SETTLE_TCK) ?
    `LPSD_CKE_LOW_CYC : `LPSD_CLOCK_SETTLE_TCK;
  localparam int POST_RST = `LPSD_POST_RESET_CYC;
  localparam int AI_MAX = `LPSD_AUTO_INIT_MAX_CYC;
  localparam int CAL_CYC = `LPSD_INITIAL_CAL_CYC;
  localparam bit CAN_POLL = POLL_AUTO_INIT &&
    `LPSD_CLK_PERIOD_PS >= `LPSD_BOOT_CLK_MIN_NS * 1000 &&
    `LPSD_CLK_PERIOD_PS <= `LPSD_BOOT_CLK_MAX_NS * 1000;
  localparam logic [3:0] BURST = (FEATURE1_VAL[2:0] == 3'h4) ? 4'h8 :
    ((FEATURE1_VAL[2:0] == 3'h3) ? 4'h4 : 4'h2);
  localparam int LW = $clog2(FIFO_DEPTH + 1);

  lpsd_ctl_e state_ff, nxt_state;
  logic [31:0] wait_ff, nxt_wait;
  logic [1:0] featIdx_ff, nxt_featIdx;
  logic [3:0] wcnt_ff, nxt_wcnt, gap_ff, nxt_gap;
  logic [LW:0] pend_ff;
  logic [4*DQ_W-1:0] wrWord_ff;
  logic cke_ff, nxt_cke, csB_ff, nxt_csB, dqOeB_ff, nxt_dqOeB;
  logic [9:0] caRise_ff, nxt_caRise, caFall_ff, nxt_caFall;
  logic [2*DQ_W-1:0] dq_ff, nxt_dq;
  logic [LW-1:0] fifoLevel;

  ////////////////////////////////////////////////////////////////////////////
  // Read-buffer room: held words, words in flight and one more burst
  wire logic waitDone = (wait_ff == 32'h0);
  wire logic push = link.devStrobe && initDone;
  wire logic room = (32'(fifoLevel) + 32'(pend_ff) + 32'(BURST)) <= 32'(FIFO_DEPTH);
  wire logic isRdWr = (cmdOp == CMD_RD) || (cmdOp == CMD_WR);
  assign cmdReady = (state_ff == C_READY) && (!isRdWr || gap_ff == 4'h0) &&
    (cmdOp != CMD_RD || room);
  wire logic take = cmdValid && cmdReady;
  wire logic [7:0] featVal = (featIdx_ff == 2'h0) ? FEATURE1_VAL :
    ((featIdx_ff == 2'h1) ? FEATURE2_VAL : FEATURE3_VAL);

  // Command word: opcode and upper field on the rising half, rest on the falling
  function automatic logic [9:0] caHi(input lpsd_cmd_e op, input logic [5:0] hi);
    return {hi, op};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: timed waits are cycle counts, left when they expire; the poll response step also ends on a strobe
  always_comb begin
    nxt_state = state_ff;
    nxt_wait = waitDone ? 32'h0 : wait_ff - 32'h1;
    nxt_featIdx = featIdx_ff;
    nxt_wcnt = wcnt_ff;
    nxt_gap = (gap_ff == 4'h0) ? 4'h0 : gap_ff - 4'h1;
    nxt_cke = 1'b1;
    nxt_csB = 1'b1;
    nxt_caRise = '0;
    nxt_caFall = '0;
    nxt_dq = '0;
    nxt_dqOeB = 1'b1;
    unique case (state_ff)
      C_CKE_LOW: begin
        nxt_cke = 1'b0;
        if (waitDone) begin
          nxt_state = C_PWR_IDLE;
          nxt_wait = 32'(POWER_UP_IDLE_CYC - 1);
        end
      end
      C_PWR_IDLE: if (waitDone) nxt_state = PRECHARGE_FIRST ? C_PREA : C_RESET;
      C_PREA: begin
        nxt_csB = 1'b0;
        nxt_caRise = caHi(CMD_PREA, 6'h00);
        nxt_state = C_RESET;
      end
      C_RESET: begin
        nxt_csB = 1'b0;
        nxt_caRise = caHi(CMD_MRW, `LPSD_MA_RESET);
        nxt_state = C_POST_RST;
        nxt_wait = 32'(POST_RST - 1);
      end
      C_POST_RST: if (waitDone) begin
        nxt_state = CAN_POLL ? C_AI_POLL : C_AI_WAIT;
        nxt_wait = 32'(AI_MAX - POST_RST);
      end
      C_AI_WAIT: if (waitDone) nxt_state = C_CAL_REQ;
      C_AI_POLL: begin
        nxt_csB = 1'b0;
        nxt_caRise = caHi(CMD_MRR, `LPSD_MA_DEVICE_INFO);
        nxt_state = C_AI_RESP;
      end
      C_AI_RESP: begin
        if (link.devStrobe)
          nxt_state = link.dq[`LPSD_AUTO_INIT_BIT] ? C_AI_POLL : C_CAL_REQ;
        else if (waitDone)
          nxt_state = C_CAL_REQ;
      end
      C_CAL_REQ: if (calGrant) begin
        nxt_csB = 1'b0;
        nxt_caRise = caHi(CMD_MRW, `LPSD_MA_IMPEDANCE_CAL);
        nxt_caFall = {2'b00, `LPSD_CAL_INIT_CODE};
        nxt_state = C_CAL_WAIT;
        nxt_wait = 32'(CAL_CYC - 1);
      end
      C_CAL_WAIT: if (waitDone) begin
        nxt_state = C_FEAT;
        nxt_featIdx = 2'h0;
      end
      C_FEAT: begin
        nxt_csB = 1'b0;
        nxt_caRise = caHi(CMD_MRW, 6'(featIdx_ff) + `LPSD_MA_FEATURE1);
        nxt_caFall = {2'b00, featVal};
        nxt_featIdx = featIdx_ff + 2'h1;
        if (featIdx_ff == 2'h2) nxt_state = C_READY;
      end
      C_READY: if (take) begin
        nxt_csB = 1'b0;
        nxt_caRise = caHi(cmdOp, {3'b000, cmdBank});
        nxt_caFall = (cmdOp == CMD_ACT) ? 10'(cmdRow) : 10'(cmdCol);
        if (isRdWr) nxt_gap = BURST;
        if (cmdOp == CMD_WR) begin
          nxt_state = C_WDATA;
          nxt_wcnt = BURST - 4'h1;
        end
      end
      C_WDATA: begin
        nxt_dqOeB = 1'b0;
        nxt_dq = wcnt_ff[0] ? wrWord_ff[2*DQ_W-1:0] : wrWord_ff[4*DQ_W-1:2*DQ_W];
        nxt_wcnt = wcnt_ff - 4'h1;
        if (wcnt_ff == 4'h0) nxt_state = C_READY;
      end
    endcase
  end

  // Sequencer and pin registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_ff <= C_CKE_LOW;
      wait_ff <= 32'(CKE_LOW - 1);
      featIdx_ff <= 2'h0;
      wcnt_ff <= 4'h0;
      gap_ff <= 4'h0;
      cke_ff <= 1'b0;
      csB_ff <= 1'b1;
      caRise_ff <= '0;
      caFall_ff <= '0;
      dq_ff <= '0;
      dqOeB_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      featIdx_ff <= nxt_featIdx;
      wcnt_ff <= nxt_wcnt;
      gap_ff <= nxt_gap;
      cke_ff <= nxt_cke;
      csB_ff <= nxt_csB;
      caRise_ff <= nxt_caRise;
      caFall_ff <= nxt_caFall;
      dq_ff <= nxt_dq;
      dqOeB_ff <= nxt_dqOeB;
    end
  end

  // Write word capture and count of read beat pairs still to arrive
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wrWord_ff <= '0;
      pend_ff <= '0;
    end else begin
      if (take && cmdOp == CMD_WR) wrWord_ff <= cmdWrData;
      pend_ff <= pend_ff + ((take && cmdOp == CMD_RD) ? (LW+1)'(BURST) : '0)
        - (LW+1)'(push && pend_ff != '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data buffer; its room gates read commands back to the user
  lpsd_fifo #(.W(2*DQ_W), .DEPTH(FIFO_DEPTH)) u_rdFifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .inValid(push),
    .inReady(),
    .inData(link.dq),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData),
    .level(fifoLevel)
  );

  assign link.cke = cke_ff;
  assign link.csB = csB_ff;
  assign link.caRise = caRise_ff;
  assign link.caFall = caFall_ff;
  assign link.ctlDq = dq_ff;
  assign link.ctlDqOeB = dqOeB_ff;
  assign initDone = (state_ff == C_READY) || (state_ff == C_WDATA);
  assign calReq = (state_ff == C_CAL_REQ) || (state_ff == C_CAL_WAIT);
endmodule

// ===== lpsd_link_properties.sv
// Timing checker for the SDRAM command link
`timescale 1ns/1ps
`include "lpsd_regs.svh"
module lpsd_link_properties import lpsd_pkg::*; (
  input wire logic ref_clk, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic cke, // Clock-enable gate
  input wire logic csB, // Chip select
  input wire logic [9:0] caRise, // Rising-half field
  input wire logic devDqOeB, // Memory drive enable
  input wire logic devStrobe, // Read beat strobe
  input wire logic ctlDqOeB // Controller drive enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Decoded link commands
  wire logic isCmd = cke && !csB;
  wire logic rdCmd = isCmd && caRise[3:0] == CMD_RD;
  wire logic wrCmd = isCmd && caRise[3:0] == CMD_WR;
  wire logic nopCyc = csB || caRise[3:0] == CMD_NOP;
  // Banks opened on the link; a read to a closed bank is refused and gives no beats
  logic [7:0] openSeen_ff;
  wire logic allClose = isCmd && (caRise[3:0] == CMD_PREA ||
    (caRise[3:0] == CMD_MRW && caRise[9:4] == `LPSD_MA_RESET));
  always_ff @(posedge ref_clk) begin
    if (!rst_b || allClose) openSeen_ff <= 8'h00;
    else if (isCmd && caRise[3:0] == CMD_ACT) openSeen_ff[caRise[6:4]] <= 1'b1;
    else if (isCmd && caRise[3:0] == CMD_PRE) openSeen_ff[caRise[6:4]] <= 1'b0;
  end
  wire logic rdServed = rdCmd && openSeen_ff[caRise[6:4]];
  ////////////////////////////////////////////////////////////////////////////////
  chk_cke_hold_low: assert property ($rose(rst_b) |-> !cke [*8])
    else $error("gate rose early");
  chk_clock_settle: assert property ($rose(cke) |-> !$past(cke, 5) && !$past(cke, 9))
    else $error("gate low too short");
  chk_idle_nop_only: assert property ($rose(cke) |-> nopCyc [*8])
    else $error("command during idle wait");
  chk_hiz_gate_low: assert property (!cke |-> devDqOeB)
    else $error("memory drives while gated");
  chk_single_driver: assert property (!devDqOeB |-> ctlDqOeB)
    else $error("both ends drive data");
  chk_rd_beats: assert property (rdServed |-> ##2 devStrobe ##1 devStrobe ##1 !devStrobe)
    else $error("read beats wrong");
  chk_wr_beats: assert property (wrCmd |-> ##1 !ctlDqOeB ##1 !ctlDqOeB ##1 ctlDqOeB)
    else $error("write beats wrong");
  chk_one_cycle_cmd: assert property (rdCmd || wrCmd |=> !(rdCmd || wrCmd))
    else $error("access held two cycles");
  // Main scenarios reached
  cover property (rdCmd);
  cover property (wrCmd);
  cover property ($rose(cke));
endmodule

// ===== testbench.sv
// Bench joining the controller end and the memory end
`timescale 1ns/1ps
module testbench import lpsd_pkg::*; ;
  typedef struct {lpsd_cmd_e op; logic [2:0] bank; logic [31:0] data; logic idle;} lpsd_row_s;
  logic ref_clk = 1'h0, rst_b = 1'h0, calGrant = 1'h0, cmdValid = 1'h0, rdReady = 1'h0;
  lpsd_cmd_e cmdOp = CMD_NOP;
  logic [2:0] cmdBank = 3'h0;
  logic [31:0] cmdWrData = 32'h0;
  wire logic initDone, calReq, cmdReady, rdValid, idleState, autoInitBusy, calBusy, cmdErr;
  wire logic [15:0] rdData;
  int miscompares = 0, numChecks = 0, n, k;
  lpsd_row_s rows [6] = '{'{CMD_ACT, 3'h0, 32'h0, 1'h0}, '{CMD_WR, 3'h0, 32'hA5C31E77, 1'h0},
    '{CMD_RD, 3'h0, 32'h0, 1'h0}, '{CMD_RD, 3'h0, 32'h0, 1'h0}, '{CMD_RD, 3'h0, 32'h0, 1'h0},
    '{CMD_RD, 3'h0, 32'h0, 1'h0}};
  lpsd_link_if #(.DQ_W(8)) lpsd_link_if_inst (.ref_clk(ref_clk));
  lpsd_mem_end #(.AUTO_INIT_CYC(20)) lpsd_mem_end_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(lpsd_link_if_inst.mem), .idleState(idleState), .autoInitBusy(autoInitBusy),
    .calBusy(calBusy), .cmdErr(cmdErr));
  lpsd_ctl_end #(.POWER_UP_IDLE_CYC(50)) lpsd_ctl_end_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(lpsd_link_if_inst.ctl), .initDone(initDone), .calReq(calReq), .calGrant(calGrant),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdBank(cmdBank),
    .cmdRow(2'h1), .cmdCol(3'h0), .cmdWrData(cmdWrData), .rdValid(rdValid),
    .rdReady(rdReady), .rdData(rdData));
  lpsd_link_properties lpsd_link_properties_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .cke(lpsd_link_if_inst.cke), .csB(lpsd_link_if_inst.csB),
    .caRise(lpsd_link_if_inst.caRise), .devDqOeB(lpsd_link_if_inst.devDqOeB),
    .devStrobe(lpsd_link_if_inst.devStrobe), .ctlDqOeB(lpsd_link_if_inst.ctlDqOeB));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and calibration slot arbiter
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) calGrant <= #1 calReq;
  task automatic step(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic testDone();
    if (miscompares == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input lpsd_row_s r);
    cmdOp = r.op;
    cmdBank = r.bank;
    cmdWrData = r.data;
    cmdValid = 1'h1;
    for (n = 0; n < 300 && cmdReady !== 1'h1; n++) step(1);
    check(n < 300, 1'h1);
    if (n == 300) testDone();
    step(1);
    cmdValid = 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    step(11);
    check(lpsd_link_if_inst.cke, 1'h0);
    check(lpsd_link_if_inst.devDqOeB, 1'h1);
    check(autoInitBusy, 1'h1);
    step(1);
    rst_b = 1'h1;
    for (n = 0; n < 3000 && initDone !== 1'h1; n++) step(1);
    check(initDone, 1'h1);
    if (n == 3000) testDone();
    check(autoInitBusy, 1'h0);
    check(calBusy, 1'h0);
    check(calReq, 1'h0);
    check(idleState, 1'h1);
    for (k = 0; k < 6; k++) begin
      send(rows[k]);
      step(8);
      check(idleState, rows[k].idle);
    end
    cmdOp = CMD_RD;
    cmdValid = 1'h1;
    step(20);
    check(cmdReady, 1'h0);
    cmdValid = 1'h0;
    rdReady = 1'h1;
    for (k = 0; k < 8; k++) begin
      check({rdValid, rdData}, {1'h1, k[0] ? 16'hA5C3 : 16'h1E77});
      step(1);
    end
    check(rdValid, 1'h0);
    send('{CMD_PRE, 3'h0, 32'h0, 1'h1});
    step(8);
    check(idleState, 1'h1);
    send('{CMD_RD, 3'h5, 32'h0, 1'h1});
    for (n = 0; n < 20 && cmdErr !== 1'h1; n++) step(1);
    check(cmdErr, 1'h1);
    testDone();
  end
endmodule
